// [src/mps_device.sv]
// Purpose: module end: ignition-driven power-on phases and ready notices
// Assumes: link lines treated as pins and resynchronised
// Notes: shutdown and mode change are user-side requests
`timescale 1ns/1ps
`default_nettype none
module mps_device #(
  parameter int unsigned N_PORTS = mps_pkg::N_PORTS,
  parameter int unsigned MS_CYCLES = mps_pkg::MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  mps_link_if.dev link,
  input wire logic i_airplane,
  input wire logic i_shutdown_req,
  input wire logic [N_PORTS-1:0] i_port_usb,
  input wire logic [N_PORTS-1:0] i_usb_configured,
  input wire logic i_wait_host_ready,
  output logic [2:0] o_state,
  output logic o_active
);
  localparam int unsigned W = mps_pkg::MS_W;

  function automatic logic in_burst(input logic [W-1:0] ms,
                                    input int unsigned start);
    in_burst = (ms >= W'(start)) &&
               (ms < W'(start + mps_pkg::BURST_LEN_MS));
  endfunction : in_burst

  // three-stage resync of ignition and emergency-off pins
  logic [2:0] ign_s;
  logic [2:0] emg_s;
  logic ign_low;
  logic emg_low;
  logic next_ign_low;
  logic next_emg_low;

  mps_pkg::mps_state_t state;
  mps_pkg::mps_state_t next_state;
  logic [W-1:0] ms;
  logic [W-1:0] next_ms;
  logic tick;
  logic [N_PORTS-1:0] pending;
  logic [N_PORTS-1:0] next_pending;
  logic [N_PORTS-1:0] port_ok;
  logic [N_PORTS-1:0] next_note;
  logic air_mode;
  logic next_air_mode;
  logic next_power_ind;
  logic next_poll_resp;
  logic next_link_rst_n;
  logic next_link_act;
  logic next_active;
  logic [N_PORTS-1:0] note_q;
  logic air_q;
  logic power_ind_q;
  logic poll_resp_q;
  logic link_rst_n_q;
  logic link_act_q;

  mps_ms_tick #(.DIV(MS_CYCLES)) u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(state != mps_pkg::MPS_OFF),
    .o_tick(tick)
  );

  // a change counts once stages two and three agree
  always_comb begin
    next_ign_low = (ign_s[1] == ign_s[2]) ? ~ign_s[2] : ign_low;
    next_emg_low = (emg_s[1] == emg_s[2]) ? ~emg_s[2] : emg_low;
  end

  always_comb begin
    for (int i = 0; i < N_PORTS; i++) begin
      port_ok[i] = !i_port_usb[i] ||
                   (i_usb_configured[i] &&
                    (!i_wait_host_ready || link.host_ready[i])); // R8
    end
  end

  always_comb begin
    next_state = state;
    next_ms = ms;
    next_pending = pending;
    next_note = '0;
    next_air_mode = air_mode;
    next_power_ind = 1'b0;
    next_poll_resp = 1'b0;
    next_link_rst_n = 1'b0;
    next_link_act = 1'b0;
    next_active = 1'b0;
    // saturating elapsed-time counter
    if (tick && ms != {W{1'b1}}) begin
      next_ms = ms + 1'b1; // R12
    end
    unique case (state)
      mps_pkg::MPS_OFF: begin
        next_ms = '0;
        next_pending = '0;
        if (ign_low) begin
          next_state = mps_pkg::MPS_RESET; // R1
        end
      end
      mps_pkg::MPS_RESET: begin
        if (ms >= W'(mps_pkg::RESET_END_MS)) begin
          next_state = mps_pkg::MPS_HWINIT; // R9
        end
      end
      mps_pkg::MPS_HWINIT: begin
        if (ms >= W'(mps_pkg::HWINIT_END_MS)) begin
          next_state = mps_pkg::MPS_FWINIT; // R9
        end
      end
      mps_pkg::MPS_FWINIT: begin
        if (in_burst(ms, mps_pkg::BURST1_MS) ||
            in_burst(ms, mps_pkg::BURST2_MS)) begin
          next_link_rst_n = 1'b1; // R11
          next_link_act = 1'b1; // R11
        end
        if (ms >= W'(mps_pkg::FWINIT_END_MS)) begin
          next_state = mps_pkg::MPS_ACTIVE; // R9
          next_pending = '1; // R5
          next_air_mode = i_airplane; // R6
          next_active = 1'b1;
        end
      end
      mps_pkg::MPS_ACTIVE: begin
        next_active = 1'b1;
        next_poll_resp = link.poll_req; // R7
        // mode change re-announces on every port
        if (i_airplane != air_mode) begin
          next_air_mode = i_airplane; // R6
          next_pending = '1; // R5
        end else begin
          next_note = pending & port_ok; // R5
          next_pending = pending & ~port_ok;
        end
        if (i_shutdown_req) begin
          next_state = mps_pkg::MPS_SHUTDOWN;
          next_ms = '0;
          next_pending = '0;
          next_note = '0;
          next_active = 1'b0;
          next_power_ind = 1'b1; // R13
        end
      end
      mps_pkg::MPS_SHUTDOWN: begin
        next_power_ind = 1'b1; // R13
        if (ms >= W'(mps_pkg::SHUTDOWN_MS)) begin
          next_state = mps_pkg::MPS_OFF;
          next_power_ind = 1'b0;
        end
      end
      default: begin
        next_state = mps_pkg::MPS_OFF;
      end
    endcase
    // emergency off drops straight to power-down, no indicator
    if (emg_low && state != mps_pkg::MPS_OFF) begin
      next_state = mps_pkg::MPS_OFF;
      next_pending = '0;
      next_note = '0;
      next_power_ind = 1'b0;
      next_poll_resp = 1'b0;
      next_link_rst_n = 1'b0;
      next_link_act = 1'b0;
      next_active = 1'b0;
    end
  end

  // reset values are the initial pin states of power-down
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ign_s <= 3'h7;
      emg_s <= 3'h7;
      ign_low <= 1'b0;
      emg_low <= 1'b0;
      state <= mps_pkg::MPS_OFF;
      ms <= '0;
      pending <= '0;
      air_mode <= 1'b0;
      note_q <= '0;
      air_q <= 1'b0;
      power_ind_q <= 1'b0;
      poll_resp_q <= 1'b0;
      link_rst_n_q <= 1'b0;
      link_act_q <= 1'b0;
      o_active <= 1'b0;
      o_state <= 3'h0;
    end else begin
      ign_s <= {ign_s[1:0], link.ign_line};
      emg_s <= {emg_s[1:0], link.emerg_line};
      ign_low <= next_ign_low;
      emg_low <= next_emg_low;
      state <= next_state;
      ms <= next_ms;
      pending <= next_pending;
      air_mode <= next_air_mode;
      note_q <= next_note;
      air_q <= next_air_mode; // R6
      power_ind_q <= next_power_ind;
      poll_resp_q <= next_poll_resp;
      link_rst_n_q <= next_link_rst_n; // R10
      link_act_q <= next_link_act;
      o_active <= next_active;
      o_state <= next_state;
    end
  end

  always_comb begin
    link.ready_note = note_q;
    link.ready_airplane = air_q;
    link.power_ind = power_ind_q;
    link.poll_resp = poll_resp_q;
    link.link_rst_n = link_rst_n_q;
    link.link_activity = link_act_q;
  end
endmodule : mps_device
`default_nettype wire

// [src/mps_pkg.sv]
// Purpose: shared constants and types for the module power-on sequencer
// Assumes: one 200 MHz clock; all phase timing counted in 1 ms ticks
// Notes: both ends and the link interface read these names
// Behaviour
// R1: ignition low in power-down starts power-on
// R2: host holds ignition low at least 100 ms
// R3: host drives ignition only open-drain
// R4: host releases ignition high after turn-on
// R5: ready notification on every command port
// R6: notification form tells normal from airplane
// R7: host waits for notification or polls
// R8: usb ports need configured and host-ready
// R9: reset, hw init, fw init, active in order
// R10: signals hold initial states until software runs
// R11: two link bursts at 11s and 13s
// R12: elapsed-ms counter picks phase and ready time
// R13: power indicator high during switch-off
package mps_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_W = 16;
  localparam int unsigned RESET_END_MS = 100;
  localparam int unsigned HWINIT_END_MS = 5000;
  localparam int unsigned FWINIT_END_MS = 36000;
  localparam int unsigned BURST1_MS = 11000;
  localparam int unsigned BURST2_MS = 13000;
  localparam int unsigned BURST_LEN_MS = 50;
  localparam int unsigned SHUTDOWN_MS = 20000;
  localparam int unsigned IGN_HOLD_MS = 100;
  localparam int unsigned POLL_GAP_MS = 100;
  localparam int unsigned N_PORTS = 3;

  typedef enum logic [2:0] {
    MPS_OFF = 3'h0,
    MPS_RESET = 3'h1,
    MPS_HWINIT = 3'h2,
    MPS_FWINIT = 3'h3,
    MPS_ACTIVE = 3'h4,
    MPS_SHUTDOWN = 3'h5
  } mps_state_t;

  typedef enum logic [2:0] {
    MPS_H_IDLE = 3'h0,
    MPS_H_IGNITE = 3'h1,
    MPS_H_WAIT = 3'h2,
    MPS_H_POLL = 3'h3,
    MPS_H_READY = 3'h4
  } mps_host_state_t;
endpackage : mps_pkg

// [src/mps_link_if.sv]
// Purpose: link between host application and module sequencer
// Assumes: ignition and emergency-off lines pulled up, driven low only
// Notes: wire level worked out here from the open-drain enables
`timescale 1ns/1ps
`default_nettype none
interface mps_link_if #(parameter int unsigned N_PORTS = mps_pkg::N_PORTS);
  logic ign_o;
  logic ign_oe;
  logic emerg_o;
  logic emerg_oe;
  logic ign_line;
  logic emerg_line;
  logic power_ind;
  logic [N_PORTS-1:0] ready_note;
  logic ready_airplane;
  logic [N_PORTS-1:0] host_ready;
  logic poll_req;
  logic poll_resp;
  logic link_rst_n;
  logic link_activity;
  // pull-up wins unless an enabled driver pulls low
  assign ign_line = ~(ign_oe & ~ign_o);
  assign emerg_line = ~(emerg_oe & ~emerg_o);
  modport dev (
    input ign_line, emerg_line, host_ready, poll_req,
    output power_ind, ready_note, ready_airplane, poll_resp,
    output link_rst_n, link_activity
  );
  modport host (
    output ign_o, ign_oe, emerg_o, emerg_oe, host_ready, poll_req,
    input power_ind, ready_note, ready_airplane, poll_resp
  );
endinterface : mps_link_if
`default_nettype wire

// [src/mps_ms_tick.sv]
// Purpose: one-cycle enable every millisecond
// Assumes: i_run low holds the divider cleared
// Notes: first tick comes a full period after i_run rises
`timescale 1ns/1ps
`default_nettype none
module mps_ms_tick #(
  parameter int unsigned DIV = mps_pkg::MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  output logic o_tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!i_run) begin
      next_cnt = '0;
    end else if (cnt == CW'(DIV - 1)) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule : mps_ms_tick
`default_nettype wire

// [src/mps_host.sv]
// Purpose: host end: ignition pulse, then wait for notice or poll
// Assumes: module end runs on the same clock, no resync needed
// Notes: ignition held one tick longer than the minimum, tick phase unknown
`timescale 1ns/1ps
`default_nettype none
module mps_host #(
  parameter int unsigned N_PORTS = mps_pkg::N_PORTS,
  parameter int unsigned MS_CYCLES = mps_pkg::MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  mps_link_if.host link,
  input wire logic i_power_on,
  input wire logic i_use_notification,
  input wire logic i_emergency_off,
  input wire logic [N_PORTS-1:0] i_rx_ready,
  output logic o_cmd_ready,
  output logic o_airplane,
  output logic o_busy
);
  localparam int unsigned W = mps_pkg::MS_W;

  mps_pkg::mps_host_state_t state;
  mps_pkg::mps_host_state_t next_state;
  logic [W-1:0] ms;
  logic [W-1:0] next_ms;
  logic tick;
  logic ign_oe_q;
  logic next_ign_oe;
  logic emg_oe_q;
  logic poll_q;
  logic next_poll;
  logic [N_PORTS-1:0] rx_ready_q;
  logic next_cmd_ready;
  logic next_airplane;
  logic next_busy;

  mps_ms_tick #(.DIV(MS_CYCLES)) u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(state == mps_pkg::MPS_H_IGNITE || state == mps_pkg::MPS_H_POLL),
    .o_tick(tick)
  );

  always_comb begin
    next_state = state;
    next_ms = ms;
    next_ign_oe = 1'b0;
    next_poll = 1'b0;
    next_cmd_ready = 1'b0;
    next_airplane = o_airplane;
    next_busy = 1'b1;
    if (tick) begin
      next_ms = ms + 1'b1;
    end
    unique case (state)
      mps_pkg::MPS_H_IDLE: begin
        next_busy = 1'b0;
        next_ms = '0;
        if (i_power_on) begin
          next_state = mps_pkg::MPS_H_IGNITE;
          next_ign_oe = 1'b1;
          next_busy = 1'b1;
        end
      end
      mps_pkg::MPS_H_IGNITE: begin
        next_ign_oe = 1'b1; // R2
        if (ms > W'(mps_pkg::IGN_HOLD_MS)) begin
          next_ign_oe = 1'b0; // R4
          next_ms = '0;
          next_state = i_use_notification ? mps_pkg::MPS_H_WAIT
                                          : mps_pkg::MPS_H_POLL;
        end
      end
      mps_pkg::MPS_H_WAIT: begin
        if (|link.ready_note) begin
          next_state = mps_pkg::MPS_H_READY; // R7
          next_cmd_ready = 1'b1;
          next_airplane = link.ready_airplane; // R6
        end
      end
      mps_pkg::MPS_H_POLL: begin
        // poll every gap until the module answers
        if (tick && ms >= W'(mps_pkg::POLL_GAP_MS - 1)) begin
          next_poll = 1'b1; // R7
          next_ms = '0;
        end
        if (link.poll_resp || (|link.ready_note)) begin
          next_state = mps_pkg::MPS_H_READY; // R7
          next_cmd_ready = 1'b1;
          next_poll = 1'b0;
          next_airplane = link.ready_airplane;
        end
      end
      mps_pkg::MPS_H_READY: begin
        next_cmd_ready = 1'b1;
        next_busy = 1'b0;
        if (|link.ready_note) begin
          next_airplane = link.ready_airplane;
        end
        if (link.power_ind) begin
          next_state = mps_pkg::MPS_H_IDLE;
          next_cmd_ready = 1'b0;
        end
      end
      default: begin
        next_state = mps_pkg::MPS_H_IDLE;
      end
    endcase
    if (i_emergency_off) begin
      next_state = mps_pkg::MPS_H_IDLE;
      next_cmd_ready = 1'b0;
      next_ign_oe = 1'b0;
      next_poll = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= mps_pkg::MPS_H_IDLE;
      ms <= '0;
      ign_oe_q <= 1'b0;
      emg_oe_q <= 1'b0;
      poll_q <= 1'b0;
      rx_ready_q <= '0;
      o_cmd_ready <= 1'b0;
      o_airplane <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      state <= next_state;
      ms <= next_ms;
      ign_oe_q <= next_ign_oe;
      emg_oe_q <= i_emergency_off;
      poll_q <= next_poll;
      rx_ready_q <= i_rx_ready;
      o_cmd_ready <= next_cmd_ready;
      o_airplane <= next_airplane;
      o_busy <= next_busy;
    end
  end

  // open-drain: data tied low, only the enable moves
  always_comb begin
    link.ign_o = 1'b0; // R3
    link.ign_oe = ign_oe_q; // R3
    link.emerg_o = 1'b0;
    link.emerg_oe = emg_oe_q;
    link.poll_req = poll_q;
    link.host_ready = rx_ready_q;
  end
endmodule : mps_host
`default_nettype wire

// [tb/mps_props.sv]
// Purpose: link-level checks between host end and module end
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the interface wires, not the phase code
`timescale 1ns/1ps
`default_nettype none
module mps_props #(
  parameter int unsigned N_PORTS = 3,
  parameter int unsigned MS_CYCLES = 200000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic ign_o,
  input wire logic ign_oe,
  input wire logic emerg_o,
  input wire logic emerg_oe,
  input wire logic emerg_line,
  input wire logic power_ind,
  input wire logic [N_PORTS-1:0] ready_note,
  input wire logic poll_req,
  input wire logic poll_resp,
  input wire logic link_rst_n,
  input wire logic link_activity
);
  localparam int unsigned IGN_MIN = 100 * MS_CYCLES;
  localparam int unsigned BURST_CYC = 50 * MS_CYCLES;
  logic [31:0] ign_cnt;
  logic [31:0] act_cnt;
  logic [31:0] next_ign_cnt;
  logic [31:0] next_act_cnt;
  // length of the current low pulse and burst, in cycles
  always_comb begin
    next_ign_cnt = ign_oe ? ign_cnt + 32'h1 : 32'h0;
    next_act_cnt = link_activity ? act_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ign_cnt <= 32'h0;
      act_cnt <= 32'h0;
    end else begin
      ign_cnt <= next_ign_cnt;
      act_cnt <= next_act_cnt;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_ign_od; ign_oe |-> !ign_o; endproperty
  a_ign_od: assert property (p_ign_od)
    else $error("ignition driven high");
  property p_emerg_od; emerg_oe |-> !emerg_o; endproperty
  a_emerg_od: assert property (p_emerg_od)
    else $error("emergency line driven high");
  property p_ign_hold; $fell(ign_oe) |-> ign_cnt >= IGN_MIN; endproperty
  a_ign_hold: assert property (p_ign_hold)
    else $error("ignition pulse too short");
  property p_ign_release; $fell(ign_oe) |-> !ign_oe [*8]; endproperty
  a_ign_release: assert property (p_ign_release)
    else $error("ignition pulled again after release");
  property p_link_match; link_rst_n == link_activity; endproperty
  a_link_match: assert property (p_link_match)
    else $error("link reset and activity disagree");
  property p_burst_len;
    $fell(link_activity) |-> act_cnt == BURST_CYC;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst length wrong");
  property p_poll; poll_resp |-> $past(poll_req); endproperty
  a_poll: assert property (p_poll)
    else $error("poll answer without poll");
  property p_note_pulse;
    |ready_note |=> (ready_note & $past(ready_note)) == '0;
  endproperty
  a_note_pulse: assert property (p_note_pulse)
    else $error("ready notice longer than one cycle");
  property p_note_pwr; power_ind |-> ready_note == '0; endproperty
  a_note_pwr: assert property (p_note_pwr)
    else $error("ready notice during switch-off");
  property p_pwr_hold; $rose(power_ind) |-> power_ind [*8]; endproperty
  a_pwr_hold: assert property (p_pwr_hold)
    else $error("power indicator dropped early");
  property p_emerg_quiet;
    $fell(emerg_line) |-> ##[1:8] (!power_ind && ready_note == '0);
  endproperty
  a_emerg_quiet: assert property (p_emerg_quiet)
    else $error("emergency off left outputs active");
endmodule : mps_props
`default_nettype wire

// [tb/tb_module_power_on_sequencer.sv]
// Purpose: host end and module end joined, full power-on run
// Assumes: ms divider cut to 1 cycle so two 36 s boots fit the run
// Notes: first boot waits for the notice, second one polls
`timescale 1ns/1ps
`default_nettype none
module tb_module_power_on_sequencer;
  localparam int unsigned MSC = 1;
  localparam int unsigned NP = 3;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic airplane = 1'b0;
  logic shut_req = 1'b0;
  logic wait_hr = 1'b1;
  logic power_on = 1'b0;
  logic use_note = 1'b1;
  logic emerg = 1'b0;
  logic [NP-1:0] port_usb = 3'h4;
  logic [NP-1:0] usb_cfg = 3'h0;
  logic [NP-1:0] rx_ready = 3'h0;
  logic [2:0] state;
  logic [2:0] prev_st = 3'h0;
  logic active, cmd_ready, host_air, busy;
  logic prev_act = 1'b0;
  logic note_air = 1'b0;
  logic [NP-1:0] note_acc = 3'h0;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int bursts = 0;
  int polls = 0;
  int t_ph [6];
  int t_burst [2];
  logic [2:0] seen_q [$];

  always #2.5 i_clk = ~i_clk;

  mps_link_if #(.N_PORTS(NP)) link ();
  mps_device #(.N_PORTS(NP), .MS_CYCLES(MSC)) i_mps_device (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link),
    .i_airplane(airplane), .i_shutdown_req(shut_req),
    .i_port_usb(port_usb), .i_usb_configured(usb_cfg),
    .i_wait_host_ready(wait_hr), .o_state(state), .o_active(active));
  mps_host #(.N_PORTS(NP), .MS_CYCLES(MSC)) i_mps_host (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link),
    .i_power_on(power_on), .i_use_notification(use_note),
    .i_emergency_off(emerg), .i_rx_ready(rx_ready),
    .o_cmd_ready(cmd_ready), .o_airplane(host_air), .o_busy(busy));
  mps_props #(.N_PORTS(NP), .MS_CYCLES(MSC)) i_mps_props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .ign_o(link.ign_o),
    .ign_oe(link.ign_oe), .emerg_o(link.emerg_o),
    .emerg_oe(link.emerg_oe), .emerg_line(link.emerg_line),
    .power_ind(link.power_ind), .ready_note(link.ready_note),
    .poll_req(link.poll_req), .poll_resp(link.poll_resp),
    .link_rst_n(link.link_rst_n), .link_activity(link.link_activity));

  // monitor on the falling edge so outputs have settled
  always @(negedge i_clk) begin
    cyc++;
    if (!i_sys_rst && state !== prev_st) begin
      if (state <= 3'h5) t_ph[state] = cyc;
      seen_q.push_back(state);
    end
    prev_st = state;
    if (link.link_activity === 1'b1 && !prev_act) begin
      if (bursts < 2) t_burst[bursts] = cyc;
      bursts++;
    end
    prev_act = link.link_activity;
    if (link.poll_resp === 1'b1) polls++;
    note_acc |= link.ready_note;
    if (|link.ready_note) note_air = link.ready_airplane;
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // tick phase is unknown, so allow a couple of ms of slack
  task automatic near(input string nm, input int exp, input int got);
    tests_run++;
    if (got < exp - 2 * MSC - 2 || got > exp + 2 * MSC + 2) begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : near

  task automatic wait_state(input logic [2:0] st, input int lim);
    int n;
    n = 0;
    while (state !== st && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    chk("o_state", st, state);
  endtask : wait_state

  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (90000) @(posedge i_clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk("state_idle", 3'h0, state);
    chk("ign_line_idle", 1'b1, link.ign_line);
    @(posedge i_clk) power_on <= 1'b1;
    @(posedge i_clk) power_on <= 1'b0;
    wait_state(3'h1, 20);
    chk("busy", 1'b1, busy);
    wait_state(3'h3, 12000);
    chk("cmd_ready_early", 1'b0, cmd_ready);
    wait_state(3'h4, 70000);
    repeat (6) @(negedge i_clk);
    chk("phase_count", 4, seen_q.size());
    for (int i = 0; i < 4; i++) chk("phase_seq", i + 1, seen_q[i]);
    near("hwinit_at", 100 * MSC, t_ph[2] - t_ph[1]);
    near("fwinit_at", 5000 * MSC, t_ph[3] - t_ph[1]);
    near("active_at", 36000 * MSC, t_ph[4] - t_ph[1]);
    chk("bursts", 2, bursts);
    near("burst1_at", 11000 * MSC, t_burst[0] - t_ph[1]);
    near("burst2_at", 13000 * MSC, t_burst[1] - t_ph[1]);
    chk("notes_boot", 3'h3, note_acc);
    chk("note_form", 1'b0, note_air);
    chk("cmd_ready", 1'b1, cmd_ready);
    chk("busy_ready", 1'b0, busy);
    chk("active", 1'b1, active);
    chk("ign_released", 1'b1, link.ign_line);
    @(posedge i_clk) note_acc = 3'h0;
    usb_cfg <= 3'h4;
    repeat (10) @(negedge i_clk);
    chk("note_wait_host", 3'h0, note_acc);
    @(posedge i_clk) rx_ready <= 3'h4;
    repeat (6) @(negedge i_clk);
    chk("note_usb", 3'h4, note_acc);
    @(posedge i_clk) note_acc = 3'h0;
    airplane <= 1'b1;
    repeat (6) @(negedge i_clk);
    chk("notes_mode", 3'h7, note_acc);
    chk("note_form_air", 1'b1, note_air);
    chk("host_airplane", 1'b1, host_air);
    @(posedge i_clk) shut_req <= 1'b1;
    @(posedge i_clk) shut_req <= 1'b0;
    wait_state(3'h5, 10);
    repeat (12) @(negedge i_clk);
    chk("power_ind", 1'b1, link.power_ind);
    chk("cmd_ready_off", 1'b0, cmd_ready);
    @(posedge i_clk) emerg <= 1'b1;
    wait_state(3'h0, 12);
    repeat (2) @(negedge i_clk);
    chk("power_ind_emerg", 1'b0, link.power_ind);
    chk("active_emerg", 1'b0, active);
    @(posedge i_clk) emerg <= 1'b0;
    // every port usb and unconfigured: no notice, host must poll
    use_note <= 1'b0;
    port_usb <= 3'h7;
    usb_cfg <= 3'h0;
    repeat (10) @(posedge i_clk);
    note_acc = 3'h0;
    power_on <= 1'b1;
    @(posedge i_clk) power_on <= 1'b0;
    wait_state(3'h1, 20);
    wait_state(3'h4, 40000);
    chk("poll_early", 0, polls);
    chk("cmd_ready_poll_early", 1'b0, cmd_ready);
    repeat (120) @(negedge i_clk);
    chk("poll_answers", 1, polls);
    chk("cmd_ready_poll", 1'b1, cmd_ready);
    chk("notes_unconfigured", 3'h0, note_acc);
    print_verdict();
  end
endmodule : tb_module_power_on_sequencer
`default_nettype wire
